// ==== cpmc_cfg.svh ====
// Constants of the clock and power mode controller: register offsets,
// field positions, reset values, key values and timing counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH

// Register offsets on the special-function register port.
`define CPMC_ADDR_PWR_CTRL 8'h87
`define CPMC_ADDR_CLK_SEL 8'h8F
`define CPMC_ADDR_WAKE_MASK 8'h9F
`define CPMC_ADDR_PWR_MGMT 8'hC4
`define CPMC_ADDR_STATUS 8'hC5
`define CPMC_ADDR_WIN_KEY 8'hC9

// Reset values.
`define CPMC_RST_CLK_SEL 8'h0C
`define CPMC_RST_WAKE_MASK 8'hFF
`define CPMC_RST_STATUS 8'h0C
`define CPMC_RST_CORE_DIV 2'b01

// Field positions.
`define CPMC_SYSTEM_CLOCK_SELECT_DIV_LSB 4
`define CPMC_SYSTEM_CLOCK_SELECT_REG_LSB 2
`define CPMC_POWER_CONTROL_REGISTER_IDLE 0
`define CPMC_POWER_CONTROL_REGISTER_STOP 1
`define CPMC_POWER_CONTROL_REGISTER_SLEEP 2
`define CPMC_POWER_CONTROL_REGISTER_BAUD 7
`define CPMC_PMR_CD_LSB 6
`define CPMC_PMR_SWB 5
`define CPMC_STAT_HIP 6
`define CPMC_STAT_LIP 5
`define CPMC_STAT_TX 1
`define CPMC_STAT_RX 0
`define CPMC_SER_RX_EN 4

// Timed window key values.
`define CPMC_KEY_FIRST 8'hAA
`define CPMC_KEY_SECOND 8'h55
`define CPMC_KEY_CLOSE 8'h00

// Timing counts, all in cycles of the clock that paces them.
`define CPMC_WIN_PERIODS 9'h100
`define CPMC_PMM_LAST 9'h100
`define CPMC_REG_WAIT_BASE 8'h10

// Interrupt line layout: lines 0 and 1 are active-low pins.
`define CPMC_INT_ACTIVE_LOW 9'h003
`define CPMC_SWB_LINES 9'h1DF

`endif

// ==== cpmc_pkg.sv ====
// Types shared by the clock and power mode controller.
// Assumes the constants header is compiled alongside.
package cpmc_pkg;

  // Power state of the core.
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_STOP = 2'b10,
    PM_REG_WAIT = 2'b11
  } cpmc_pm_state_t;

  // One request on the register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpmc_bus_req_t;

  // Clock enables for the three clock groups.
  typedef struct packed {
    logic sysTick;
    logic coreTick;
    logic periphTick;
  } cpmc_clk_en_t;

  // Oscillator and regulator controls.
  typedef struct packed {
    logic fastOscOn;
    logic slowSelected;
    logic mainRegOn;
  } cpmc_osc_ctrl_t;

endpackage

// ==== cpmc_top.sv ====
// Clock selection, pre-division, timed write window, STOP/SLEEP/IDLE and
// reduced-speed mode control with automatic switchback.
// Assumes clk is the fast oscillator; the slow source, pins and the reset
// pin arrive asynchronously; core status inputs share clk.
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_top (
  input wire logic clk,
  input wire logic rst,
  input cpmc_pkg::cpmc_bus_req_t busReq,
  output logic [7:0] rdata,
  input wire logic [8:0] extIntPin,
  input wire logic resetPinN,
  input wire logic serial0RxPin,
  input wire logic slowOscIn,
  input wire logic watchdogReset,
  input wire logic hiPrioIsrActive,
  input wire logic loPrioIsrActive,
  input wire logic serial0TxActive,
  input wire logic serial0RxActive,
  input wire logic [7:0] serial0Control,
  input wire logic serial0TxLoad,
  input wire logic [8:0] intEnable,
  input wire logic [8:0] intNotBlocked,
  output cpmc_pkg::cpmc_clk_en_t clkEn,
  output cpmc_pkg::cpmc_osc_ctrl_t oscCtrl,
  output logic idleActive,
  output logic stopActive,
  output logic reducedSpeedMode,
  output logic wakeVectorReq,
  output logic resumeNoVector
);

  // Divider limit (divisor minus one) for a pre-divider code.
  function automatic logic [10:0] divLimit(input logic [3:0] code);
    logic [11:0] pow;
    pow = 12'h000;
    if (code == 4'h0) begin
      divLimit = 11'h000;
    end else if (code <= 4'h8) begin
      divLimit = {6'h00, code, 1'b0} - 11'h001;
    end else begin
      pow = (12'h001 << (code - 4'h4)) - 12'h001;
      divLimit = pow[10:0];
    end
  endfunction

  // Three-stage synchronisers and the filtered copies of async inputs.
  logic [11:0] syncA_q;
  logic [11:0] syncB_q;
  logic [11:0] syncC_q;
  logic [11:0] filt_q;
  logic [11:0] filtPrev_q;
  wire [11:0] asyncRaw = {slowOscIn, serial0RxPin, resetPinN, extIntPin};
  // A bit changes only once the second and third stages agree.
  wire [11:0] filt_d = (syncB_q & syncC_q) | (filt_q & (syncB_q | syncC_q));

  // Reset image of the clock select register, split into its fields below.
  localparam logic [7:0] clkSelRst = `CPMC_RST_CLK_SEL;

  // Register state.
  logic [3:0] divCode_q;
  logic [1:0] regWaitSel_q;
  logic [1:0] clkSel_q;
  logic [7:0] wakeMask_q;
  logic baudDouble_q;
  logic [1:0] coreDiv_q;
  logic swbEn_q;
  logic keyArmed_q;
  logic [8:0] winCnt_q;
  logic [7:0] rdata_q;
  logic sleepReq_q;
  logic [7:0] regCnt_q;
  logic [10:0] preCnt_q;
  logic [8:0] pmmCnt_q;
  logic wakeVector_q;
  logic noVector_q;
  cpmc_pkg::cpmc_pm_state_t state_q;
  cpmc_pkg::cpmc_pm_state_t state_d;
  cpmc_pkg::cpmc_clk_en_t clkEn_q;

  // Interrupt levels made active-high, and their rising edges.
  wire [8:0] intLvl = filt_q[8:0] ^ `CPMC_INT_ACTIVE_LOW;
  wire [8:0] intLvlPrev = filtPrev_q[8:0] ^ `CPMC_INT_ACTIVE_LOW;
  wire [8:0] intEdge = intLvl & ~intLvlPrev;
  wire rstPinAct = ~filt_q[9];
  wire rxFall = filtPrev_q[10] & ~filt_q[10];
  wire slowEdge = filt_q[11] & ~filtPrev_q[11];

  // Address decode of the register port.
  wire selPcon = busReq.addr == `CPMC_ADDR_PWR_CTRL;
  wire selClk = busReq.addr == `CPMC_ADDR_CLK_SEL;
  wire selMask = busReq.addr == `CPMC_ADDR_WAKE_MASK;
  wire selPmr = busReq.addr == `CPMC_ADDR_PWR_MGMT;
  wire selStat = busReq.addr == `CPMC_ADDR_STATUS;
  wire selKey = busReq.addr == `CPMC_ADDR_WIN_KEY;
  wire winOpen = winCnt_q != 9'h000;
  wire wrPcon = busReq.wr && selPcon;
  wire wrClk = busReq.wr && selClk && winOpen;
  wire wrMask = busReq.wr && selMask && winOpen;
  wire wrPmr = busReq.wr && selPmr;
  wire keyWr = busReq.wr && selKey;
  wire keyOpen = keyWr && keyArmed_q && (busReq.wdata == `CPMC_KEY_SECOND);

  // Read values; reserved bits read zero except status bits 3:2, which read one; regulator field reads zero.
  wire [7:0] statusWord = `CPMC_RST_STATUS | {1'b0, hiPrioIsrActive, loPrioIsrActive,
    3'b000, serial0TxActive, serial0RxActive};
  wire [7:0] clkWord = {divCode_q, 2'b00, clkSel_q};
  wire [7:0] pmrWord = {coreDiv_q, swbEn_q, 5'h00};
  wire [7:0] rdSel = selStat ? statusWord :
    selClk ? clkWord :
    selMask ? wakeMask_q :
    selPmr ? pmrWord :
    selPcon ? {baudDouble_q, 7'h00} :
    selKey ? {7'h00, winOpen} : 8'h00;

  // Wake lines in mask bit order 8,7,6,4,3,2,1,0; line 5 cannot wake.
  wire [8:0] wakeLines = {wakeMask_q[7:5], 1'b0, wakeMask_q[4:0]};
  // Only pin-driven lines reach wake logic; clocked sources never do.
  wire wakeHit = |(intEdge & wakeLines);
  wire wakeEnabled = |(intEdge & wakeLines & intEnable);
  wire idleExit = rstPinAct || (|(intLvl & intEnable));

  // Reduced speed and switchback events.
  wire reduced_speed_mode = coreDiv_q == 2'b11;
  wire swbInt = |(intLvl & intEnable & intNotBlocked & `CPMC_SWB_LINES);
  wire swbRx = rxFall && serial0Control[`CPMC_SER_RX_EN];
  wire swEvent = swbEn_q && reduced_speed_mode && (swbInt || swbRx || serial0TxLoad);
  wire forceFull = rstPinAct || watchdogReset;

  // Pre-divider tick and system clock tick selection.
  wire [10:0] preLim = divLimit(divCode_q);
  wire fastTick = preCnt_q >= preLim;
  wire clockRuns = (state_q == cpmc_pkg::PM_RUN) || (state_q == cpmc_pkg::PM_IDLE);
  wire sysTick_d = clockRuns && (clkSel_q[1] ? slowEdge : fastTick);
  wire coreGate = reduced_speed_mode ? (pmmCnt_q == `CPMC_PMM_LAST) : 1'b1;
  wire coreTick_d = sysTick_d && coreGate && (state_q == cpmc_pkg::PM_RUN);
  wire [7:0] regShift = `CPMC_REG_WAIT_BASE << regWaitSel_q;
  wire [7:0] regLim = regShift - 8'h01;
  wire regDone = slowEdge && (regCnt_q >= regLim);

  // Synchronisers and edge history.
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_q <= 12'h000;
      syncB_q <= 12'h000;
      syncC_q <= 12'h000;
      filt_q <= 12'h000;
      filtPrev_q <= 12'h000;
    end else begin
      syncA_q <= asyncRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      filt_q <= filt_d;
      filtPrev_q <= filt_q;
    end
  end

  // Timed window: key pair opens or extends it, zero closes it.
  always_ff @(posedge clk) begin
    if (rst) begin
      keyArmed_q <= 1'b0;
      winCnt_q <= 9'h000;
    end else begin
      if (keyWr) begin
        keyArmed_q <= busReq.wdata == `CPMC_KEY_FIRST;
      end
      if (keyOpen) begin
        winCnt_q <= `CPMC_WIN_PERIODS;
      end else if (keyWr && (busReq.wdata == `CPMC_KEY_CLOSE)) begin
        winCnt_q <= 9'h000;
      end else if (winOpen && clkEn_q.sysTick) begin
        winCnt_q <= winCnt_q - 9'h001;
      end
    end
  end

  // Clock selection and wake mask; STOP wake forces the fast source.
  always_ff @(posedge clk) begin
    if (rst) begin
      divCode_q <= clkSelRst[7:4];
      regWaitSel_q <= clkSelRst[3:2];
      clkSel_q <= clkSelRst[1:0];
      wakeMask_q <= `CPMC_RST_WAKE_MASK;
    end else begin
      if (state_q == cpmc_pkg::PM_STOP && (wakeHit || rstPinAct)) begin
        clkSel_q <= 2'b00;
      end else if (wrClk) begin
        clkSel_q <= busReq.wdata[1:0];
      end
      if (wrClk) begin
        divCode_q <= busReq.wdata[`CPMC_SYSTEM_CLOCK_SELECT_DIV_LSB +: 4];
        regWaitSel_q <= busReq.wdata[`CPMC_SYSTEM_CLOCK_SELECT_REG_LSB +: 2];
      end
      if (wrMask) begin
        wakeMask_q <= busReq.wdata;
      end
    end
  end

  // Power management register; switchback and resets win over writes.
  always_ff @(posedge clk) begin
    if (rst) begin
      coreDiv_q <= `CPMC_RST_CORE_DIV;
      swbEn_q <= 1'b0;
      baudDouble_q <= 1'b0;
    end else begin
      if (forceFull || swEvent) begin
        coreDiv_q <= 2'b01;
      end else if (wrPmr) begin
        coreDiv_q <= busReq.wdata[`CPMC_PMR_CD_LSB +: 2];
      end
      if (wrPmr) begin
        swbEn_q <= busReq.wdata[`CPMC_PMR_SWB];
      end
      if (wrPcon) begin
        baudDouble_q <= busReq.wdata[`CPMC_POWER_CONTROL_REGISTER_BAUD];
      end
    end
  end

  // Power state sequencing.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cpmc_pkg::PM_RUN: begin
        if (wrPcon && busReq.wdata[`CPMC_POWER_CONTROL_REGISTER_STOP]) begin
          state_d = cpmc_pkg::PM_STOP;
        end else if (wrPcon && busReq.wdata[`CPMC_POWER_CONTROL_REGISTER_IDLE]) begin
          state_d = cpmc_pkg::PM_IDLE;
        end
      end
      cpmc_pkg::PM_IDLE: begin
        if (idleExit) begin
          state_d = cpmc_pkg::PM_RUN;
        end
      end
      cpmc_pkg::PM_STOP: begin
        if (wakeHit || rstPinAct) begin
          state_d = sleepReq_q ? cpmc_pkg::PM_REG_WAIT : cpmc_pkg::PM_RUN;
        end
      end
      cpmc_pkg::PM_REG_WAIT: begin
        if (regDone) begin
          state_d = cpmc_pkg::PM_RUN;
        end
      end
    endcase
  end

  // State, sleep request and the regulator wait counter.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= cpmc_pkg::PM_REG_WAIT;
      sleepReq_q <= 1'b0;
      regCnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == cpmc_pkg::PM_RUN && wrPcon && busReq.wdata[`CPMC_POWER_CONTROL_REGISTER_STOP]) begin
        sleepReq_q <= busReq.wdata[`CPMC_POWER_CONTROL_REGISTER_SLEEP];
      end else if (state_d == cpmc_pkg::PM_RUN) begin
        sleepReq_q <= 1'b0;
      end
      if (state_q != cpmc_pkg::PM_REG_WAIT) begin
        regCnt_q <= 8'h00;
      end else if (slowEdge) begin
        regCnt_q <= regCnt_q + 8'h01;
      end
    end
  end

  // Resume pulses: vector only when the waking line is enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeVector_q <= 1'b0;
      noVector_q <= 1'b0;
    end else begin
      wakeVector_q <= (state_q == cpmc_pkg::PM_IDLE && idleExit && !rstPinAct) ||
        (state_q == cpmc_pkg::PM_STOP && wakeEnabled && !rstPinAct);
      noVector_q <= state_q == cpmc_pkg::PM_STOP && wakeHit && !wakeEnabled &&
        !rstPinAct;
    end
  end

  // Pre-divider and reduced-speed counters, and the clock enables.
  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt_q <= 11'h000;
      pmmCnt_q <= 9'h000;
      clkEn_q <= '0;
    end else begin
      preCnt_q <= fastTick ? 11'h000 : preCnt_q + 11'h001;
      if (!reduced_speed_mode) begin
        pmmCnt_q <= 9'h000;
      end else if (sysTick_d) begin
        pmmCnt_q <= coreGate ? 9'h000 : pmmCnt_q + 9'h001;
      end
      clkEn_q.sysTick <= sysTick_d;
      clkEn_q.coreTick <= coreTick_d;
      clkEn_q.periphTick <= sysTick_d;
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (busReq.rd) begin
      rdata_q <= rdSel;
    end
  end

  // Outputs: rdata, clkEn and the resume pulses straight from flip-flops, the rest decoded from registered state.
  assign rdata = rdata_q;
  assign clkEn = clkEn_q;
  assign oscCtrl.fastOscOn = state_q != cpmc_pkg::PM_STOP;
  assign oscCtrl.slowSelected = clkSel_q[1];
  assign oscCtrl.mainRegOn = !(state_q == cpmc_pkg::PM_STOP && sleepReq_q);
  assign idleActive = state_q == cpmc_pkg::PM_IDLE;
  assign stopActive = state_q == cpmc_pkg::PM_STOP;
  assign reducedSpeedMode = reduced_speed_mode;
  assign wakeVectorReq = wakeVector_q;
  assign resumeNoVector = noVector_q;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_unlock;
    (keyWr && busReq.wdata == `CPMC_KEY_FIRST) ##1 !keyWr ##1
      (keyWr && busReq.wdata == `CPMC_KEY_SECOND);
  endsequence

  sequence s_opened;
    winOpen ##1 winOpen;
  endsequence

  property p_unlock;
    s_unlock |=> (winCnt_q >= 9'h0FF) and s_opened;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key pair did not open window");

  property p_win_close;
    (keyWr && busReq.wdata == `CPMC_KEY_CLOSE) |=> !winOpen;
  endproperty
  a_win_close: assert property (p_win_close) else $error("zero key left window open");

  property p_clk_locked;
    (busReq.wr && selClk && !winOpen) |=> $stable({divCode_q, regWaitSel_q});
  endproperty
  a_clk_locked: assert property (p_clk_locked) else $error("locked clock write took");

  property p_status;
    (busReq.rd && selStat) |=> rdata == {1'b0, $past(hiPrioIsrActive),
      $past(loPrioIsrActive), 3'b011, $past(serial0TxActive), $past(serial0RxActive)};
  endproperty
  a_status: assert property (p_status) else $error("status read mismatch");

  property p_reg_zero;
    (busReq.rd && selClk) |=> rdata[3:2] == 2'b00;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("regulator field read nonzero");

  property p_pmm_rate;
    (clkEn_q.coreTick && reduced_speed_mode && $past(reduced_speed_mode)) |-> $past(pmmCnt_q) == `CPMC_PMM_LAST;
  endproperty
  a_pmm_rate: assert property (p_pmm_rate) else $error("core tick off reduced rate");

  property p_swb;
    (swEvent || forceFull) |=> coreDiv_q == 2'b01;
  endproperty
  a_swb: assert property (p_swb) else $error("switchback did not restore speed");

  property p_stop_wake;
    (stopActive && wakeHit) |=> !stopActive && clkSel_q == 2'b00 && oscCtrl.fastOscOn;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake failed");

  property p_idle_gate;
    idleActive |=> !clkEn_q.coreTick;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("core ticked in idle");

  property p_idle_exit;
    (idleActive && idleExit) |=> !idleActive && state_q == cpmc_pkg::PM_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle did not clear");

endmodule

// ==== cpmc_top_tb_top.sv ====
// Self-checking testbench for the clock and power mode controller.
// Assumes the constants header and the package are compiled before it.
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_top_tb_top;
  logic clk = 1'b0; // System clock, 100 MHz.
  logic rst = 1'b1; // Synchronous reset, held for five cycles.
  cpmc_pkg::cpmc_bus_req_t busReq = '0; // Register port request.
  logic [7:0] rdata; // Registered read data.
  logic [8:0] extIntPin = 9'h003; // Lines 0 and 1 rest high, they are active low.
  logic resetPinN = 1'b1; // Reset pin released, pulled low only for the reset pin exit.
  logic [1:0] slowCnt_q = 2'h0; // Divides clk by four for the slow source.
  logic watchdogReset = 1'b0; // Watchdog reset request.
  logic serial0RxPin = 1'b1; // Receive line idles high.
  logic [3:0] actIn = 4'h0; // Activity: hi prio, lo prio, transmit, receive.
  logic [7:0] serial0Control = 8'h00; // Serial control, bit 4 enables receive.
  logic serial0TxLoad = 1'b0; // Transmit buffer load pulse.
  logic [8:0] intEnable = 9'h000; // Per-line interrupt enables.
  logic [8:0] intNotBlocked = 9'h000; // Per-line not-blocked flags.
  cpmc_pkg::cpmc_clk_en_t clkEn; // Clock enables.
  cpmc_pkg::cpmc_osc_ctrl_t oscCtrl; // Oscillator controls.
  logic idleActive, stopActive, reducedSpeedMode, wakeVectorReq, resumeNoVector;
  int miscompares = 0; // Mismatches seen.
  int n_compared = 0; // Comparisons made.
  int divs[16] = '{1, 2, 4, 6, 8, 10, 12, 14, 16, 32, 64, 128, 256, 512, 1024, 2048};
  logic [7:0] statExp[4] = '{8'h0D, 8'h0E, 8'h2C, 8'h4C}; // Status per activity bit.

  // Clock generator.
  always #5 clk = ~clk;

  // Slow source runs at a quarter of clk so the regulator wait stays short.
  always @(posedge clk) begin
    slowCnt_q <= slowCnt_q + 2'h1;
  end

  cpmc_top i_dut (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
    .extIntPin(extIntPin), .resetPinN(resetPinN), .serial0RxPin(serial0RxPin),
    .slowOscIn(slowCnt_q[1]), .watchdogReset(watchdogReset),
    .hiPrioIsrActive(actIn[3]), .loPrioIsrActive(actIn[2]),
    .serial0TxActive(actIn[1]), .serial0RxActive(actIn[0]),
    .serial0Control(serial0Control), .serial0TxLoad(serial0TxLoad),
    .intEnable(intEnable), .intNotBlocked(intNotBlocked), .clkEn(clkEn),
    .oscCtrl(oscCtrl), .idleActive(idleActive), .stopActive(stopActive),
    .reducedSpeedMode(reducedSpeedMode), .wakeVectorReq(wakeVectorReq),
    .resumeNoVector(resumeNoVector));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares a register value or flag.
  task automatic chkv(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Compares a count worked out by the bench.
  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      miscompares++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    chkv(nm, e, d);
  endtask

  // Lets n edges pass and samples just after the last.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts the edges until the core ticks again, with a limit.
  task automatic waitcore(output int n);
    n = 0;
    while (clkEn.coreTick !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Opens the protected write window with the key pair.
  task automatic unlock();
    wr(`CPMC_ADDR_WIN_KEY, 8'hAA);
    wr(`CPMC_ADDR_WIN_KEY, 8'h55);
  endtask

  // Measures the cycles between the second and third tick seen.
  task automatic gap(input bit core, output int n);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while ((core ? clkEn.coreTick : clkEn.sysTick) !== 1'b1 && n < 5000);
    end
  endtask

  // Collects the wake pulses over n cycles.
  task automatic watch(input int n, output logic sv, output logic snv);
    sv = 1'b0;
    snv = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      sv = sv | wakeVectorReq;
      snv = snv | resumeNoVector;
    end
  endtask

  // A start bit: the line drops, then returns high.
  task automatic rxfall();
    @(posedge clk);
    serial0RxPin <= 1'b0;
    repeat (6) @(posedge clk);
    serial0RxPin <= 1'b1;
  endtask

  // Ends a hung run as a failure.
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    report_and_stop();
  end

  // Main test sequence.
  initial begin
    int n;
    logic sv;
    logic snv;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    waitcore(n);
    chkn("regulator wait in range", 1, int'(n > 500 && n < 700));
    rchk(`CPMC_ADDR_STATUS, 8'h0C, "status");
    rchk(`CPMC_ADDR_CLK_SEL, 8'h00, "clock select");
    rchk(`CPMC_ADDR_WAKE_MASK, 8'hFF, "wake mask");
    rchk(`CPMC_ADDR_PWR_MGMT, 8'h40, "power mgmt");
    rchk(8'h10, 8'h00, "unmapped");
    $display("test reset values done");
    // Each activity input shows in its own status bit.
    for (int k = 0; k < 4; k++) begin
      actIn <= 4'h1 << k;
      rchk(`CPMC_ADDR_STATUS, statExp[k], "status bit");
    end
    actIn <= 4'h0;
    $display("test status done");
    // Locked writes drop; the key pair opens a window that times out.
    wr(`CPMC_ADDR_CLK_SEL, 8'h5E);
    rchk(`CPMC_ADDR_CLK_SEL, 8'h00, "locked clock select");
    unlock();
    rchk(`CPMC_ADDR_WIN_KEY, 8'h01, "window open");
    wr(`CPMC_ADDR_CLK_SEL, 8'h0D);
    rchk(`CPMC_ADDR_CLK_SEL, 8'h01, "clock select");
    wr(`CPMC_ADDR_WAKE_MASK, 8'h5A);
    rchk(`CPMC_ADDR_WAKE_MASK, 8'h5A, "wake mask");
    settle(225);
    rchk(`CPMC_ADDR_WIN_KEY, 8'h01, "window late");
    settle(25);
    rchk(`CPMC_ADDR_WIN_KEY, 8'h00, "window expired");
    unlock();
    wr(`CPMC_ADDR_WIN_KEY, 8'h00);
    wr(`CPMC_ADDR_WAKE_MASK, 8'hFF);
    rchk(`CPMC_ADDR_WAKE_MASK, 8'h5A, "closed mask");
    $display("test window done");
    // Every source code; the upper two select the slow clock.
    unlock();
    for (int k = 0; k < 4; k++) begin
      wr(`CPMC_ADDR_CLK_SEL, 8'(k));
      settle(2);
      chkv("slow selected", 8'(k >= 2), oscCtrl.slowSelected);
    end
    wr(`CPMC_ADDR_CLK_SEL, 8'h00);
    $display("test source done");
    // Every pre-divider code against its divisor.
    for (int k = 0; k < 16; k++) begin
      unlock();
      wr(`CPMC_ADDR_CLK_SEL, {4'(k > 0 ? k - 1 : 0), 4'h2});
      wr(`CPMC_ADDR_CLK_SEL, {k[3:0], 4'h2});
      wr(`CPMC_ADDR_CLK_SEL, {k[3:0], 4'h0});
      gap(1'b0, n);
      chkn("system tick gap", divs[k], n);
    end
    unlock();
    wr(`CPMC_ADDR_CLK_SEL, 8'h00);
    $display("test pre-divider done");
    // Reduced speed and each way out of it.
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    settle(2);
    chkv("reduced speed", 8'h01, reducedSpeedMode);
    gap(1'b1, n);
    chkn("core tick gap", 257, n);
    @(posedge clk);
    serial0TxLoad <= 1'b1;
    @(posedge clk);
    serial0TxLoad <= 1'b0;
    settle(20);
    chkv("after transmit load", 8'h00, reducedSpeedMode);
    rchk(`CPMC_ADDR_PWR_MGMT, 8'h60, "power mgmt");
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    rxfall();
    settle(8);
    chkv("start bit unarmed", 8'h01, reducedSpeedMode);
    serial0Control <= 8'h10;
    rxfall();
    settle(8);
    chkv("start bit armed", 8'h00, reducedSpeedMode);
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    intEnable <= 9'h024;
    intNotBlocked <= 9'h020;
    extIntPin <= 9'h027;
    settle(8);
    chkv("blocked or line 5", 8'h01, reducedSpeedMode);
    intNotBlocked <= 9'h024;
    settle(8);
    chkv("unblocked line", 8'h00, reducedSpeedMode);
    extIntPin <= 9'h003;
    intEnable <= 9'h000;
    intNotBlocked <= 9'h000;
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    wr(`CPMC_ADDR_PWR_MGMT, 8'h60);
    settle(2);
    chkv("written back", 8'h00, reducedSpeedMode);
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    @(posedge clk);
    watchdogReset <= 1'b1;
    @(posedge clk);
    watchdogReset <= 1'b0;
    settle(4);
    chkv("watchdog exit", 8'h00, reducedSpeedMode);
    wr(`CPMC_ADDR_PWR_MGMT, 8'hE0);
    resetPinN <= 1'b0;
    settle(6);
    resetPinN <= 1'b1;
    settle(6);
    chkv("reset pin exit", 8'h00, reducedSpeedMode);
    $display("test reduced speed done");
    // Idle halts the core tick and ends on an enabled line.
    rchk(`CPMC_ADDR_STATUS, 8'h0C, "status before idle");
    intEnable <= 9'h008;
    wr(`CPMC_ADDR_PWR_CTRL, 8'h01);
    settle(2);
    chkv("idle", 8'h01, idleActive);
    n = 0;
    sv = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      n += int'(clkEn.coreTick === 1'b1);
      sv = sv | clkEn.periphTick;
    end
    chkn("core ticks in idle", 0, n);
    chkv("peripheral tick in idle", 8'h01, sv);
    extIntPin <= 9'h00B;
    watch(10, sv, snv);
    chkv("idle exit", 8'h00, idleActive);
    chkv("vector request", 8'h01, sv);
    extIntPin <= 9'h003;
    intEnable <= 9'h000;
    $display("test idle done");
    // Stop: held, masked and clocked lines do not wake; an edge does.
    unlock();
    extIntPin <= 9'h083;
    wr(`CPMC_ADDR_CLK_SEL, 8'h02);
    wr(`CPMC_ADDR_WAKE_MASK, 8'hFB);
    wr(`CPMC_ADDR_WIN_KEY, 8'h00);
    wr(`CPMC_ADDR_PWR_CTRL, 8'h02);
    settle(4);
    chkv("stop", 8'h01, stopActive);
    chkv("fast oscillator off", 8'h00, oscCtrl.fastOscOn);
    extIntPin <= 9'h0A7;
    settle(10);
    chkv("no wake", 8'h01, stopActive);
    extIntPin <= 9'h0E7;
    watch(10, sv, snv);
    chkv("stop exit", 8'h00, stopActive);
    chkv("resume without vector", 8'h01, snv);
    chkv("no vector", 8'h00, sv);
    chkv("fast oscillator on", 8'h01, oscCtrl.fastOscOn);
    chkv("fast source", 8'h00, oscCtrl.slowSelected);
    rchk(`CPMC_ADDR_CLK_SEL, 8'h00, "clock select");
    extIntPin <= 9'h003;
    // Sleep drops the main regulator and waits the short regulator count on wake.
    wr(`CPMC_ADDR_PWR_CTRL, 8'h06);
    settle(4);
    chkv("regulator off in sleep", 8'h00, oscCtrl.mainRegOn);
    extIntPin <= 9'h043;
    waitcore(n);
    chkn("sleep regulator wait", 1, int'(n > 60 && n < 90));
    chkv("sleep exit", 8'h00, stopActive);
    chkv("regulator on", 8'h01, oscCtrl.mainRegOn);
    extIntPin <= 9'h003;
    $display("test stop done");
    report_and_stop();
  end
endmodule
